// File: logic/cpu_register_set_pkg.sv
package cpu_register_set_pkg;

  // register bus map
  localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
  localparam int          CTRL_BREAK_EN = 0;
  localparam int          CTRL_MONITOR  = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h0;
  localparam int          STAT_MASK     = 0;
  localparam int          STAT_BREAK    = 1;
  localparam int          STAT_BUSY     = 2;
  localparam int          STAT_PEND_LSB = 4;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'b0;

  // core register reset values
  localparam logic [15:0] SP_RESET    = 16'h00ff;
  localparam logic [7:0]  SP_LOW_LOAD = 8'hff;
  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic [15:0] INDEX_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [7:0]  CCR_RESET   = 8'h68;
  localparam logic [7:0]  CCR_ONES    = 8'h60;

  // condition_flags bit positions
  localparam int FLAG_V = 7;
  localparam int FLAG_H = 4;
  localparam int FLAG_I = 3;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;

  // vectors
  localparam logic [15:0] RESET_VEC_HI   = 16'hfffe;
  localparam logic [15:0] RESET_VEC_LO   = 16'hffff;
  localparam logic [15:0] TRAP_VEC       = 16'hfffc;
  localparam logic [15:0] TRAP_VEC_MON   = 16'hfefc;
  localparam logic [15:0] IRQ_VEC_TOP    = 16'hfffa;
  localparam int          IRQ_COUNT      = 4;

  typedef enum logic [4:0] {
    OP_NONE, OP_FETCH, OP_JUMP, OP_LOAD_A, OP_LOAD_X, OP_LOAD_H,
    OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_ORA, OP_EOR,
    OP_ASL, OP_LSR, OP_ROL, OP_ROR, OP_DAA, OP_STACK_LOW_RELOAD,
    OP_PUSH, OP_PUSH_INDEX_HIGH, OP_PULL_INDEX_HIGH, OP_WRITE_FLAGS,
    OP_UNMASK_INTERRUPTS, OP_MASK_INTERRUPTS, OP_SOFTWARE_TRAP,
    OP_RETURN_FROM_INTERRUPT
  } op_t;

  typedef enum logic [4:0] {
    ST_RST_HI, ST_RST_LO, ST_RUN,
    ST_PUSH_PCL, ST_PUSH_PCH, ST_PUSH_X, ST_PUSH_A, ST_PUSH_CCR,
    ST_SET_MASK, ST_VEC_HI, ST_VEC_LO,
    ST_PULL_CCR, ST_PULL_A, ST_PULL_X, ST_PULL_PCH, ST_PULL_PCL
  } seq_state_t;

  typedef struct packed {
    logic [7:0] result;
    logic [7:0] flags;
  } alu_out_t;

endpackage

// File: logic/cpu_register_set.sv
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
// Summary of operation
// - 8-bit accumulator holds ALU operands, results
// - 16-bit index pair from high, low bytes
// - stack pointer forced to 00ff on reset
// - stack low reload sets low byte ff
// - stack pointer decrements on push, increments pull
// - program counter increments per fetch, loads jumps
// - reset loads program counter from fffe, ffff
// - flag bits 6 and 5 read one
// - overflow flag tracks signed overflow, signed branches
// - half carry from bit 3 on adds
// - decimal adjust uses half carry and carry
// - mask bit blocks maskable interrupts
// - stack registers, then set mask, then vector
// - interrupt entry never pushes index high byte
// - highest priority pending request serviced first
// - return pulls registers including saved mask
// - reset sets mask; only unmask op or return pulling a clear mask clears it
// - negative flag copies result bit 7
// - zero flag set for zero result
// - carry from bit 7, borrow, shifts
// - break finishes instruction, traps via fffc/fefc
// - return ends break once request released
module cpu_register_set (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_hsel,
  input  wire logic [31:0]               i_haddr,
  input  wire logic [1:0]                i_htrans,
  input  wire logic                      i_hwrite,
  input  wire logic [2:0]                i_hsize,
  input  wire logic [31:0]               i_hwdata,
  input  wire logic                      i_hready,
  output logic                           o_hreadyout,
  output logic                           o_hresp,
  output logic [31:0]                    o_hrdata,
  input  cpu_register_set_pkg::op_t      i_op,
  input  wire logic [7:0]                i_operand,
  input  wire logic [15:0]               i_target,
  input  wire logic                      i_insn_done,
  input  wire logic [3:0]                i_irq_req,
  input  wire logic                      i_break_req,
  input  wire logic [7:0]                i_mem_rdata,
  output logic [15:0]                    o_mem_addr,
  output logic                           o_mem_rd,
  output logic                           o_mem_wr,
  output logic [7:0]                     o_mem_wdata,
  output logic                           o_busy,
  output logic [7:0]                     o_accumulator,
  output logic [15:0]                    o_index_pair,
  output logic [15:0]                    o_stack_pointer,
  output logic [15:0]                    o_program_counter,
  output logic [7:0]                     o_condition_flags,
  output logic                           o_branch_greater,
  output logic                           o_branch_greater_equal,
  output logic                           o_branch_less_equal,
  output logic                           o_branch_less
);
  import cpu_register_set_pkg::*;

  seq_state_t  state;
  logic [7:0]  acc;
  logic [15:0] index;
  logic [15:0] sp;
  logic [15:0] pc;
  logic [7:0]  condition_flags;
  logic [1:0]  ctrl;
  logic        break_active;
  logic [15:0] vec_addr;
  logic        bus_wr;
  logic [31:0] bus_addr;
  logic        run;
  logic        break_pend;
  logic        irq_pend;
  logic [1:0]  irq_idx;
  alu_out_t    alu;

  // bits 6 and 5 always one
  function automatic logic [7:0] fix_flags(input logic [7:0] v);
    fix_flags = v | CCR_ONES;
  endfunction

  function automatic logic [15:0] irq_vector(input logic [1:0] idx);
    irq_vector = IRQ_VEC_TOP - {13'h0000, idx, 1'b0};
  endfunction

  function automatic alu_out_t alu_calc(input op_t op, input logic [7:0] a,
                                        input logic [7:0] m, input logic [7:0] f);
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] res;
    logic [7:0] fl;
    logic [7:0] fix;
    sum = 9'h000;
    low = 5'h00;
    res = a;
    fl  = f;
    fix = 8'h00;
    case (op)
      OP_ADD, OP_ADC: begin
        sum = {1'b0, a} + {1'b0, m} + {8'h00, (op == OP_ADC) & f[FLAG_C]};
        low = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, (op == OP_ADC) & f[FLAG_C]};
        res = sum[7:0];
        fl[FLAG_C] = sum[8];
        fl[FLAG_H] = low[4];
        fl[FLAG_V] = (a[7] == m[7]) && (res[7] != a[7]);
      end
      OP_SUB, OP_SBC: begin
        sum = {1'b0, a} - {1'b0, m} - {8'h00, (op == OP_SBC) & f[FLAG_C]};
        res = sum[7:0];
        fl[FLAG_C] = sum[8];
        fl[FLAG_V] = (a[7] != m[7]) && (res[7] != a[7]);
      end
      OP_AND, OP_ORA, OP_EOR, OP_LOAD_A: begin
        res = (op == OP_AND) ? (a & m) : (op == OP_ORA) ? (a | m) :
              (op == OP_EOR) ? (a ^ m) : m;
        fl[FLAG_V] = 1'b0;
      end
      OP_ASL, OP_ROL: begin
        res = {a[6:0], (op == OP_ROL) & f[FLAG_C]};
        fl[FLAG_C] = a[7];
        fl[FLAG_V] = res[7] ^ a[7];
      end
      OP_LSR, OP_ROR: begin
        res = {(op == OP_ROR) & f[FLAG_C], a[7:1]};
        fl[FLAG_C] = a[0];
        fl[FLAG_V] = res[7] ^ a[0];
      end
      OP_DAA: begin
        if (f[FLAG_H] || (a[3:0] > 4'h9)) begin
          fix[3:0] = 4'h6;
        end
        if (f[FLAG_C] || (a > 8'h99)) begin
          fix[7:4] = 4'h6;
        end
        res = a + fix;
        fl[FLAG_C] = fix[6];
      end
      default: begin
        res = a;
      end
    endcase
    fl[FLAG_N] = res[7];
    fl[FLAG_Z] = (res == 8'h00);
    alu_calc = '{result: res, flags: fix_flags(fl)};
  endfunction

  assign run        = (state == ST_RUN);
  assign break_pend = i_break_req && ctrl[CTRL_BREAK_EN] && !break_active;
  assign irq_pend   = (|i_irq_req) && !condition_flags[FLAG_I];
  assign alu        = alu_calc(i_op, acc, i_operand, condition_flags);

  // lowest index wins
  always_comb begin
    irq_idx = 2'h0;
    for (int k = IRQ_COUNT - 1; k >= 0; k--) begin
      if (i_irq_req[k]) begin
        irq_idx = 2'(k);
      end
    end
  end

  // sequencer
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_RST_HI;
    end else begin
      case (state)
        ST_RST_HI:   state <= ST_RST_LO;
        ST_RST_LO:   state <= ST_RUN;
        ST_RUN: begin
          if (i_op == OP_RETURN_FROM_INTERRUPT) begin
            state <= ST_PULL_CCR;
          end else if (i_op == OP_SOFTWARE_TRAP) begin
            state <= ST_PUSH_PCL;
          end else if (i_insn_done && (break_pend || irq_pend)) begin
            state <= ST_PUSH_PCL;
          end
        end
        ST_PUSH_PCL: state <= ST_PUSH_PCH;
        ST_PUSH_PCH: state <= ST_PUSH_X;
        ST_PUSH_X:   state <= ST_PUSH_A;
        ST_PUSH_A:   state <= ST_PUSH_CCR;
        ST_PUSH_CCR: state <= ST_SET_MASK;
        ST_SET_MASK: state <= ST_VEC_HI;
        ST_VEC_HI:   state <= ST_VEC_LO;
        ST_PULL_CCR: state <= ST_PULL_A;
        ST_PULL_A:   state <= ST_PULL_X;
        ST_PULL_X:   state <= ST_PULL_PCH;
        ST_PULL_PCH: state <= ST_PULL_PCL;
        default:     state <= ST_RUN;
      endcase
    end
  end

  // trap and interrupt vector choice
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vec_addr <= TRAP_VEC;
    end else if (run) begin
      if (i_op == OP_SOFTWARE_TRAP || (i_insn_done && break_pend)) begin
        vec_addr <= ctrl[CTRL_MONITOR] ? TRAP_VEC_MON : TRAP_VEC;
      end else if (i_insn_done && irq_pend) begin
        vec_addr <= irq_vector(irq_idx);
      end
    end
  end

  // break tracking
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      break_active <= 1'b0;
    end else if (run && i_op != OP_RETURN_FROM_INTERRUPT && i_op != OP_SOFTWARE_TRAP
                 && i_insn_done && break_pend) begin
      break_active <= 1'b1;
    end else if (state == ST_PULL_PCL && !i_break_req) begin
      break_active <= 1'b0;
    end
  end

  // memory port
  always_comb begin
    o_mem_addr  = sp;
    o_mem_rd    = 1'b0;
    o_mem_wr    = 1'b0;
    o_mem_wdata = 8'h00;
    case (state)
      ST_RST_HI:   begin o_mem_addr = RESET_VEC_HI; o_mem_rd = 1'b1; end
      ST_RST_LO:   begin o_mem_addr = RESET_VEC_LO; o_mem_rd = 1'b1; end
      ST_PUSH_PCL: begin o_mem_wr = 1'b1; o_mem_wdata = pc[7:0]; end
      ST_PUSH_PCH: begin o_mem_wr = 1'b1; o_mem_wdata = pc[15:8]; end
      ST_PUSH_X:   begin o_mem_wr = 1'b1; o_mem_wdata = index[7:0]; end
      ST_PUSH_A:   begin o_mem_wr = 1'b1; o_mem_wdata = acc; end
      ST_PUSH_CCR: begin o_mem_wr = 1'b1; o_mem_wdata = condition_flags; end
      ST_VEC_HI:   begin o_mem_addr = vec_addr; o_mem_rd = 1'b1; end
      ST_VEC_LO:   begin o_mem_addr = vec_addr + 16'h0001; o_mem_rd = 1'b1; end
      ST_PULL_CCR, ST_PULL_A, ST_PULL_X, ST_PULL_PCH, ST_PULL_PCL: begin
        o_mem_addr = sp + 16'h0001;
        o_mem_rd   = 1'b1;
      end
      ST_RUN: begin
        if (i_op == OP_PUSH) begin
          o_mem_wr    = 1'b1;
          o_mem_wdata = i_operand;
        end else if (i_op == OP_PUSH_INDEX_HIGH) begin
          o_mem_wr    = 1'b1;
          o_mem_wdata = index[15:8];
        end else if (i_op == OP_PULL_INDEX_HIGH) begin
          o_mem_addr = sp + 16'h0001;
          o_mem_rd   = 1'b1;
        end
      end
      default: begin
        o_mem_addr = sp;
      end
    endcase
  end

  // stack pointer
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sp <= SP_RESET;
    end else if (o_mem_wr) begin
      sp <= sp - 16'h0001;
    end else if (o_mem_rd && (state inside {ST_PULL_CCR, ST_PULL_A, ST_PULL_X, ST_PULL_PCH,
                 ST_PULL_PCL} || (run && i_op == OP_PULL_INDEX_HIGH))) begin
      sp <= sp + 16'h0001;
    end else if (run && i_op == OP_STACK_LOW_RELOAD) begin
      sp[7:0] <= SP_LOW_LOAD;
    end
  end

  // program counter
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc <= PC_RESET;
    end else begin
      case (state)
        ST_RST_HI, ST_VEC_HI, ST_PULL_PCH: pc[15:8] <= i_mem_rdata;
        ST_RST_LO, ST_VEC_LO, ST_PULL_PCL: pc[7:0]  <= i_mem_rdata;
        ST_RUN: begin
          if (i_op == OP_FETCH) begin
            pc <= pc + 16'h0001;
          end else if (i_op == OP_JUMP) begin
            pc <= i_target;
          end
        end
        default: pc <= pc;
      endcase
    end
  end

  // accumulator
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc <= ACC_RESET;
    end else if (state == ST_PULL_A) begin
      acc <= i_mem_rdata;
    end else if (run && (i_op inside {OP_LOAD_A, OP_ADD, OP_ADC, OP_SUB, OP_SBC,
             OP_AND, OP_ORA, OP_EOR, OP_ASL, OP_LSR, OP_ROL, OP_ROR, OP_DAA})) begin
      acc <= alu.result;
    end
  end

  // index pair
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      index <= INDEX_RESET;
    end else if (state == ST_PULL_X) begin
      index[7:0] <= i_mem_rdata;
    end else if (run && i_op == OP_LOAD_X) begin
      index[7:0] <= i_operand;
    end else if (run && i_op == OP_LOAD_H) begin
      index[15:8] <= i_operand;
    end else if (run && i_op == OP_PULL_INDEX_HIGH) begin
      index[15:8] <= i_mem_rdata;
    end
  end

  // condition flags
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      condition_flags <= CCR_RESET;
    end else if (state == ST_SET_MASK) begin
      condition_flags[FLAG_I] <= 1'b1;
    end else if (state == ST_PULL_CCR) begin
      condition_flags <= fix_flags(i_mem_rdata);
    end else if (run) begin
      case (i_op)
        OP_LOAD_A, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_ORA, OP_EOR,
        OP_ASL, OP_LSR, OP_ROL, OP_ROR, OP_DAA: condition_flags <= alu.flags;
        OP_WRITE_FLAGS:       condition_flags <= fix_flags({i_operand[7:4], condition_flags[FLAG_I],
                                                i_operand[2:0]});
        OP_UNMASK_INTERRUPTS: condition_flags[FLAG_I] <= 1'b0;
        OP_MASK_INTERRUPTS:   condition_flags[FLAG_I] <= 1'b1;
        default:              condition_flags <= condition_flags;
      endcase
    end
  end

  assign o_accumulator          = acc;
  assign o_index_pair           = index;
  assign o_stack_pointer        = sp;
  assign o_program_counter      = pc;
  assign o_condition_flags      = fix_flags(condition_flags);
  assign o_busy                 = !run;
  assign o_branch_greater_equal = !(condition_flags[FLAG_N] ^ condition_flags[FLAG_V]);
  assign o_branch_less          = condition_flags[FLAG_N] ^ condition_flags[FLAG_V];
  assign o_branch_greater       = !condition_flags[FLAG_Z] && !(condition_flags[FLAG_N] ^ condition_flags[FLAG_V]);
  assign o_branch_less_equal    = condition_flags[FLAG_Z] || (condition_flags[FLAG_N] ^ condition_flags[FLAG_V]);

  // bus slave, control and status only
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_wr   <= 1'b0;
      bus_addr <= 32'h0000_0000;
    end else if (i_hready) begin
      bus_wr   <= i_hsel && (i_htrans == HTRANS_NONSEQ) && i_hwrite;
      bus_addr <= i_haddr;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (bus_wr && bus_addr == CTRL_OFFSET) begin
      ctrl <= i_hwdata[1:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hrdata <= 32'h0000_0000;
    end else if (i_hready && i_hsel && i_htrans == HTRANS_NONSEQ && !i_hwrite) begin
      if (i_haddr == CTRL_OFFSET) begin
        o_hrdata <= {30'h0000_0000, ctrl};
      end else if (i_haddr == STATUS_OFFSET) begin
        o_hrdata <= {24'h00_0000, i_irq_req, 1'b0, !run, break_active,
                     condition_flags[FLAG_I]};
      end else begin
        o_hrdata <= 32'h0000_0000;
      end
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp     = HRESP_OKAY;

  // checks
  sequence s_push_frame;
    state == ST_PUSH_PCL ##1 state == ST_PUSH_PCH ##1 state == ST_PUSH_X
      ##1 state == ST_PUSH_A ##1 state == ST_PUSH_CCR;
  endsequence

  sequence s_mask_then_vector;
    state == ST_SET_MASK ##1 (condition_flags[FLAG_I] && state == ST_VEC_HI);
  endsequence

  property p_ones_fixed;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      condition_flags[6:5] == 2'b11 && o_condition_flags[6:5] == 2'b11;
  endproperty
  a_ones_fixed: assert property (p_ones_fixed) else $error("flag bits 6,5 not one");

  property p_low_reload;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      run && i_op == OP_STACK_LOW_RELOAD |=>
        sp[7:0] == 8'hff && sp[15:8] == $past(sp[15:8]);
  endproperty
  a_low_reload: assert property (p_low_reload) else $error("stack low reload wrong");

  property p_push_dec;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      run && i_op == OP_PUSH |=> sp == $past(sp) - 16'h0001;
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push did not decrement");

  property p_fetch_inc;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      run && i_op == OP_FETCH |=> pc == $past(pc) + 16'h0001;
  endproperty
  a_fetch_inc: assert property (p_fetch_inc) else $error("fetch did not advance");

  property p_reset_vector;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      state == ST_RST_HI |-> o_mem_addr == 16'hfffe ##1
        (o_mem_addr == 16'hffff && pc[15:8] == $past(i_mem_rdata));
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("reset vector bad");

  property p_masked;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      run && i_op == OP_NONE && condition_flags[FLAG_I] && !break_pend && i_insn_done |=> run;
  endproperty
  a_masked: assert property (p_masked) else $error("masked request taken");

  property p_break_end;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      state == ST_PULL_PCL && !i_break_req |=> !break_active;
  endproperty
  a_break_end: assert property (p_break_end) else $error("break not ended");

  property p_entry_frame;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      state == ST_PUSH_PCL |-> s_push_frame ##1 s_mask_then_vector;
  endproperty
  a_entry_frame: assert property (p_entry_frame) else $error("entry order bad");

  property p_mask_clear;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      $fell(condition_flags[FLAG_I]) |->
        $past(run && i_op == OP_UNMASK_INTERRUPTS) || $past(state == ST_PULL_CCR);
  endproperty
  a_mask_clear: assert property (p_mask_clear) else $error("mask cleared wrongly");

  property p_zero_flag;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      run && i_op == OP_LOAD_A |=> condition_flags[FLAG_Z] == (acc == 8'h00) && condition_flags[FLAG_N] == acc[7];
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero or negative flag");

  property p_break_vector;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      run && i_op == OP_NONE && i_insn_done && break_pend |=>
        vec_addr == ($past(ctrl[CTRL_MONITOR]) ? 16'hfefc : 16'hfffc) && break_active;
  endproperty
  a_break_vector: assert property (p_break_vector) else $error("break vector bad");

endmodule // cpu_register_set

// File: verif/cpu_mem_model.sv
`timescale 1ns/1ps
module cpu_mem_model (
  input  wire logic        i_sys_clk,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_rd;
  initial begin
    foreach (mem[k]) mem[k] = 8'h00;
    mem[16'hfffe] = 8'h12;
    mem[16'hffff] = 8'h34;
    mem[16'hfff8] = 8'hab;
    mem[16'hfff9] = 8'hcd;
    mem[16'hfefc] = 8'h9a;
    mem[16'hfefd] = 8'hbc;
    mem[16'hfffc] = 8'h56;
    mem[16'hfffd] = 8'h78;
    last_rd = 8'h00;
  end
  // data line not driven outside reads shows inverse of last byte
  assign o_rdata = i_rd ? mem[i_addr] : ~last_rd;
  always @(posedge i_sys_clk) begin
    if (i_rd) last_rd <= mem[i_addr];
    if (i_wr) mem[i_addr] <= i_wdata;
  end
endmodule // cpu_mem_model

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import cpu_register_set_pkg::*;
  logic        i_sys_clk, i_rst_n, i_hsel, i_hwrite, i_insn_done, i_break_req;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
  logic [1:0]  i_htrans;
  logic [2:0]  i_hsize;
  logic [3:0]  i_irq_req;
  logic [7:0]  i_operand, i_mem_rdata, o_mem_wdata, o_accumulator, o_condition_flags;
  logic [15:0] i_target, o_mem_addr, o_index_pair, o_stack_pointer, o_program_counter;
  logic        o_hreadyout, o_hresp, o_mem_rd, o_mem_wr, o_busy;
  logic        o_branch_greater, o_branch_greater_equal, o_branch_less_equal, o_branch_less;
  op_t         i_op;
  int          fail_count, total_checks;
  cpu_register_set uut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
    .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .o_hrdata(o_hrdata), .i_op(i_op), .i_operand(i_operand),
    .i_target(i_target), .i_insn_done(i_insn_done), .i_irq_req(i_irq_req),
    .i_break_req(i_break_req), .i_mem_rdata(i_mem_rdata), .o_mem_addr(o_mem_addr),
    .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .o_busy(o_busy),
    .o_accumulator(o_accumulator), .o_index_pair(o_index_pair),
    .o_stack_pointer(o_stack_pointer), .o_program_counter(o_program_counter),
    .o_condition_flags(o_condition_flags), .o_branch_greater(o_branch_greater),
    .o_branch_greater_equal(o_branch_greater_equal),
    .o_branch_less_equal(o_branch_less_equal), .o_branch_less(o_branch_less));
  cpu_mem_model mem_model (.i_sys_clk(i_sys_clk), .i_addr(o_mem_addr), .i_rd(o_mem_rd),
    .i_wr(o_mem_wr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic op(input op_t o, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_op <= o;
    i_operand <= v;
    @(posedge i_sys_clk);
    i_op <= OP_NONE;
    #1;
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    @(posedge i_sys_clk);
    i_htrans <= HTRANS_NONSEQ;
    i_haddr <= a;
    i_hwrite <= wr;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 50);
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 100);
    rd = o_hrdata;
    #1;
  endtask
  task automatic pulse_done();
    @(posedge i_sys_clk);
    i_insn_done <= 1'b1;
    @(posedge i_sys_clk);
    i_insn_done <= 1'b0;
    #1;
  endtask
  task automatic wait_idle();
    #1;
    for (int n = 0; n < 20 && o_busy !== 1'b0; n++) begin
      @(posedge i_sys_clk);
      #1;
    end
    chk("busy", o_busy, 1'b0);
  endtask
  task automatic t_reset();
    repeat (3) @(posedge i_sys_clk);
    #1;
    chk("sp", o_stack_pointer, 16'h00ff);
    chk("pc", o_program_counter, 16'h1234);
    chk("flags", o_condition_flags, 8'h68);
    $display("test reset done");
  endtask
  task automatic t_bus();
    ahb(1'b0, STATUS_OFFSET, 32'h0);
    chk("status", rd[15:0], 16'h0001);
    ahb(1'b0, 32'h0000_0040, 32'h0);
    chk("unmapped", rd[15:0], 16'h0000);
    chk("resp", o_hresp, HRESP_OKAY);
    ahb(1'b1, CTRL_OFFSET, 32'h0000_0002);
    ahb(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl", rd[15:0], 16'h0002);
    @(posedge i_sys_clk) i_irq_req <= 4'h1;
    pulse_done();
    chk("masked busy", o_busy, 1'b0);
    chk("masked pc", o_program_counter, 16'h1234);
    @(posedge i_sys_clk) i_irq_req <= 4'h0;
    $display("test bus and mask done");
  endtask
  task automatic t_alu();
    op(OP_LOAD_A, 8'h78);
    op(OP_ADD, 8'h08);
    chk("acc", o_accumulator, 8'h80);
    chk("flags", o_condition_flags, 8'hfc);
    op(OP_ADD, 8'h80);
    chk("flags", o_condition_flags, 8'heb);
    chk("branches", {o_branch_greater, o_branch_greater_equal, o_branch_less_equal,
        o_branch_less}, 4'h3);
    op(OP_LOAD_A, 8'h09);
    op(OP_ADD, 8'h08);
    chk("flags", o_condition_flags, 8'h78);
    op(OP_DAA, 8'h00);
    chk("daa", o_accumulator, 8'h17);
    op(OP_LOAD_A, 8'h00);
    op(OP_SUB, 8'h01);
    chk("borrow", o_condition_flags[FLAG_C], 1'b1);
    op(OP_ADC, 8'h00);
    chk("adc flags", o_condition_flags, 8'h7b);
    op(OP_ROR, 8'h00);
    chk("ror", {o_accumulator, o_condition_flags}, 16'h80fc);
    $display("test alu done");
  endtask
  task automatic t_stack();
    op(OP_PUSH, 8'hc3);
    chk("sp push", o_stack_pointer, 16'h00fe);
    op(OP_PULL_INDEX_HIGH, 8'h00);
    chk("sp pull", o_stack_pointer, 16'h00ff);
    chk("h pulled", o_index_pair[15:8], 8'hc3);
    op(OP_PUSH, 8'h00);
    op(OP_STACK_LOW_RELOAD, 8'h00);
    chk("sp reload", o_stack_pointer, 16'h00ff);
    op(OP_LOAD_H, 8'ha5);
    op(OP_LOAD_X, 8'h5a);
    chk("index", o_index_pair, 16'ha55a);
    op(OP_WRITE_FLAGS, 8'h00);
    chk("flags", o_condition_flags, 8'h68);
    op(OP_UNMASK_INTERRUPTS, 8'h00);
    chk("flags", o_condition_flags, 8'h60);
    op(OP_WRITE_FLAGS, 8'hff);
    chk("flags", o_condition_flags, 8'hf7);
    $display("test stack and flags done");
  endtask
  task automatic t_irq();
    @(posedge i_sys_clk) i_target <= 16'h2000;
    op(OP_JUMP, 8'h00);
    op(OP_FETCH, 8'h00);
    chk("pc", o_program_counter, 16'h2001);
    @(posedge i_sys_clk) i_irq_req <= 4'h6;
    pulse_done();
    chk("entry busy", o_busy, 1'b1);
    @(posedge i_sys_clk) i_irq_req <= 4'h0;
    wait_idle();
    chk("vector", o_program_counter, 16'habcd);
    chk("sp", o_stack_pointer, 16'h00fa);
    chk("saved flags", mem_model.mem[16'h00fb], 8'hf7);
    chk("saved pcl", mem_model.mem[16'h00ff], 8'h01);
    chk("mask", o_condition_flags[FLAG_I], 1'b1);
    op(OP_RETURN_FROM_INTERRUPT, 8'h00);
    wait_idle();
    chk("pc", o_program_counter, 16'h2001);
    chk("sp", o_stack_pointer, 16'h00ff);
    chk("flags", o_condition_flags, 8'hf7);
    $display("test interrupt done");
  endtask
  task automatic t_break();
    ahb(1'b1, CTRL_OFFSET, 32'h0000_0003);
    @(posedge i_sys_clk) i_break_req <= 1'b1;
    pulse_done();
    wait_idle();
    chk("break vector", o_program_counter, 16'h9abc);
    ahb(1'b0, STATUS_OFFSET, 32'h0);
    chk("status", rd[15:0], 16'h0003);
    @(posedge i_sys_clk) i_break_req <= 1'b0;
    op(OP_RETURN_FROM_INTERRUPT, 8'h00);
    wait_idle();
    chk("pc", o_program_counter, 16'h2001);
    ahb(1'b0, STATUS_OFFSET, 32'h0);
    chk("status", rd[15:0], 16'h0000);
    $display("test break done");
  endtask
  task automatic t_trap();
    ahb(1'b1, CTRL_OFFSET, 32'h0000_0000);
    op(OP_SOFTWARE_TRAP, 8'h00);
    chk("trap busy", o_busy, 1'b1);
    wait_idle();
    chk("trap vector", o_program_counter, 16'h5678);
    chk("trap mask", o_condition_flags[FLAG_I], 1'b1);
    op(OP_RETURN_FROM_INTERRUPT, 8'h00);
    wait_idle();
    chk("trap return", o_program_counter, 16'h2001);
    chk("trap flags", o_condition_flags, 8'hf7);
    $display("test trap done");
  endtask
  initial begin
    {i_rst_n, i_hsel, i_hwrite, i_insn_done, i_break_req} = 5'b01000;
    i_haddr = 32'h0;
    i_hwdata = 32'h0;
    i_htrans = 2'h0;
    i_hsize = 3'h2;
    i_irq_req = 4'h0;
    i_operand = 8'h00;
    i_target = 16'h0000;
    i_op = OP_NONE;
    fail_count = 0;
    total_checks = 0;
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_bus();
    t_alu();
    t_stack();
    t_irq();
    t_break();
    t_trap();
    final_report();
  end
  initial begin
    repeat (3000) @(posedge i_sys_clk);
    fail_count++;
    final_report();
  end
endmodule // tb_top
